/* logic/pmfc_pkg.sv */
// pmfc_pkg: register map, field layout, reset values and modes of the pixel compositor
package pmfc_pkg;

	// ****************************************
	// register byte offsets on the apb bus
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PMASK = 8'h04;
	localparam logic [7:0] OFS_OMASK = 8'h08;
	localparam logic [7:0] OFS_LADDR = 8'h0C;
	localparam logic [7:0] OFS_LDATA = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MUX_LSB = 2;
	localparam int CTRL_COMP_BIT = 5;
	localparam int LADDR_TBL_LSB = 8;
	localparam int LADDR_CH_LSB = 10;
	localparam int STAT_PHASE_LSB = 1;
	localparam int STAT_MODE_LSB = 4;

	// ****************************************
	// reset values and limits
	// ****************************************
	localparam logic [2:0] MUX_MIN = 3'h2;
	localparam logic [2:0] MUX_RST = MUX_MIN;
	localparam logic [7:0] PMASK_RST = 8'hFF;
	localparam logic [1:0] OMASK_RST = 2'h0;

	// ****************************************
	// tables and pixel modes
	// ****************************************
	localparam logic [1:0] TBL_RGB = 2'h0;
	localparam logic [1:0] TBL_PSE = 2'h1;
	localparam logic [1:0] TBL_OVL = 2'h2;
	localparam int NUM_CH = 3;
	localparam int LUT_DEPTH = 256;
	localparam int OVL_DEPTH = 4;

	typedef enum logic [1:0] {PMFC_MODE_8, PMFC_MODE_16, PMFC_MODE_32, PMFC_MODE_RSV} pmfc_mode_t;
	localparam pmfc_mode_t MODE_RST = PMFC_MODE_8;

endpackage

/* logic/pmfc_chan_if.sv */
// pmfc_chan_if: lookup and table access bundle between the compositor core and one colour channel
`timescale 1ns/1ps
interface pmfc_chan_if;
	logic wr_en;
	logic [1:0] wr_tbl;
	logic [7:0] wr_idx;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic [7:0] rgb_idx;
	logic [7:0] pse_idx;
	logic [1:0] ovl_idx;
	logic use_pseudo;
	logic ovl_hit;
	logic force_zero;
	logic [7:0] colour;

	modport ctl (output wr_en, wr_tbl, wr_idx, wr_data, rgb_idx, pse_idx, ovl_idx, use_pseudo, ovl_hit,
		force_zero, input rd_data, colour);
	modport chan (input wr_en, wr_tbl, wr_idx, wr_data, rgb_idx, pse_idx, ovl_idx, use_pseudo, ovl_hit,
		force_zero, output rd_data, colour);
endinterface

/* logic/pmfc_sync.sv */
// pmfc_sync: two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module pmfc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// a bundle needs at least one bit
	if (W < 1) begin : g_bad_w
		$error("W must be at least 1");
	end

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pmfc_sync_st_t;

	pmfc_sync_st_t st;
	pmfc_sync_st_t next_st;

	// first stage feeds only the second stage
	always_comb begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.s2;

endmodule

/* logic/pmfc_channel.sv */
// pmfc_channel: one colour channel with rgb, pseudo and overlay tables
`timescale 1ns/1ps
module pmfc_channel import pmfc_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// lookup and table port
	pmfc_chan_if.chan ch
);

	typedef struct packed {
		logic [LUT_DEPTH-1:0][7:0] rgb;
		logic [LUT_DEPTH-1:0][7:0] pse;
		logic [OVL_DEPTH-1:0][7:0] ovl;
		logic [7:0] colour;
	} pmfc_chan_st_t;

	pmfc_chan_st_t st;
	pmfc_chan_st_t next_st;

	// table writes and the per-dot colour choice
	always_comb begin
		next_st = st;
		if (ch.wr_en) begin
			case (ch.wr_tbl)
				TBL_RGB: next_st.rgb[ch.wr_idx] = ch.wr_data;
				TBL_PSE: next_st.pse[ch.wr_idx] = ch.wr_data;
				TBL_OVL: next_st.ovl[ch.wr_idx[1:0]] = ch.wr_data;
				default: ;
			endcase
		end
		if (ch.force_zero) begin
			next_st.colour = 8'h00;
		end else if (ch.ovl_hit) begin
			next_st.colour = st.ovl[ch.ovl_idx];
		end else if (ch.use_pseudo) begin
			next_st.colour = st.pse[ch.pse_idx];
		end else begin
			next_st.colour = st.rgb[ch.rgb_idx];
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// readback of the addressed entry
	assign ch.rd_data = (ch.wr_tbl == TBL_RGB) ? st.rgb[ch.wr_idx] :
		(ch.wr_tbl == TBL_PSE) ? st.pse[ch.wr_idx] :
		(ch.wr_tbl == TBL_OVL) ? st.ovl[ch.wr_idx[1:0]] : 8'h00;
	assign ch.colour = st.colour;

endmodule

/* logic/pmfc_top.sv */
// pmfc_top: pixel multiplexer, field decoder and overlay compositor with apb registers
//
// Behaviour
// - 8/16/32 bit pixels, serialised 2..5 to 1
// - 8 bit pixels use pseudo tables
// - 16 bit: red 15-10, green 9-4, blue 3-0
// - 16 bit components left-justified, low bits zero
// - 32 bit: rgb bytes high, pseudo low byte
// - each 32 bit dot shows exactly one field
// - pin control: field select pins choose
// - value control: masked pseudo zero shows rgb
// - choice may change on every pixel
// - dot rate is input rate times factor
// - dots up to 150MHz, inputs at low rate
// - overlay mask register enables overlays
// - overlays serialised with their own pixel
// - per channel two 256x8 tables, 3 overlays
// - pseudo value ANDed with pseudo mask
// - nonzero masked overlay picks overlay colour
// - new group captured each input rising edge
// - blank low forces zero colour
`timescale 1ns/1ps
module pmfc_top import pmfc_pkg::*; #(
	parameter int MAX_MUX = 5
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// low rate pixel pins
	input wire logic low_rate_input_clock,
	input wire logic [32*MAX_MUX-1:0] pix_in,
	input wire logic [MAX_MUX-1:0] field_choose_pins,
	input wire logic [2*MAX_MUX-1:0] overlay_in,
	input wire logic blank_n,
	// dot rate colour stream
	output logic dot_valid,
	output logic [7:0] red,
	output logic [7:0] green,
	output logic [7:0] blue
);

	// ****************************************
	// elaboration check
	// ****************************************
	if (MAX_MUX < 2 || MAX_MUX > 5) begin : g_bad_mux
		$error("MAX_MUX must lie between 2 and 5");
	end

	localparam logic [2:0] MUX_MAX = 3'(MAX_MUX);

	typedef struct packed {
		logic [32*MAX_MUX-1:0] pix;
		logic [MAX_MUX-1:0] sel;
		logic [2*MAX_MUX-1:0] ovl;
		logic blank_n;
	} pmfc_grp_t;

	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] prdata;
		pmfc_mode_t mode;
		logic [2:0] mux;
		logic comp_val;
		logic [7:0] pmask;
		logic [1:0] omask;
		logic [7:0] lidx;
		logic [1:0] ltbl;
		logic [1:0] lch;
		logic clk_prev;
		pmfc_grp_t prev_grp;
		pmfc_grp_t grp;
		logic busy;
		logic [2:0] phase;
		logic [2:0] gmux;
		pmfc_mode_t gmode;
		logic [NUM_CH-1:0][7:0] s_rgb;
		logic [7:0] s_pse;
		logic s_use_p;
		logic s_ohit;
		logic [1:0] s_oidx;
		logic s_zero;
		logic s_val;
		logic out_val;
	} pmfc_st_t;

	pmfc_st_t st;
	pmfc_st_t next_st;

	// ****************************************
	// pin synchronisers
	// ****************************************
	pmfc_grp_t pin_grp;
	logic clk_s;
	pmfc_grp_t grp_s;

	assign pin_grp = '{pix: pix_in, sel: field_choose_pins, ovl: overlay_in, blank_n: blank_n};

	pmfc_sync #(
		.W($bits(pmfc_grp_t) + 1)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({low_rate_input_clock, pin_grp}),
		.q({clk_s, grp_s})
	);

	// ****************************************
	// colour channels
	// ****************************************
	logic lut_wr;
	logic [NUM_CH-1:0][7:0] colour_w;
	logic [NUM_CH-1:0][7:0] rd_w;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		pmfc_chan_if chan ();

		// each channel sees the shared multiplexer output
		assign chan.wr_en = lut_wr && st.lch == 2'(c);
		assign chan.wr_tbl = st.ltbl;
		assign chan.wr_idx = st.lidx;
		assign chan.wr_data = pwdata[7:0];
		assign chan.rgb_idx = st.s_rgb[c];
		assign chan.pse_idx = st.s_pse;
		assign chan.ovl_idx = st.s_oidx;
		assign chan.use_pseudo = st.s_use_p;
		assign chan.ovl_hit = st.s_ohit;
		assign chan.force_zero = st.s_zero;
		assign colour_w[c] = chan.colour;
		assign rd_w[c] = chan.rd_data;

		pmfc_channel u_chan (
			.pclk(pclk),
			.presetn(presetn),
			.ch(chan.chan)
		);
	end

	// ****************************************
	// apb decode
	// ****************************************
	logic acc;
	logic wr_fire;
	logic hit;
	logic [31:0] rd_val;

	assign acc = psel && penable;
	assign wr_fire = acc && st.ack && pwrite && hit;
	assign lut_wr = wr_fire && paddr == OFS_LDATA;

	// read multiplexer and address hit
	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			OFS_CTRL: begin
				rd_val[CTRL_MODE_LSB +: 2] = st.mode;
				rd_val[CTRL_MUX_LSB +: 3] = st.mux;
				rd_val[CTRL_COMP_BIT] = st.comp_val;
			end
			OFS_PMASK: rd_val[7:0] = st.pmask;
			OFS_OMASK: rd_val[1:0] = st.omask;
			OFS_LADDR: begin
				rd_val[7:0] = st.lidx;
				rd_val[LADDR_TBL_LSB +: 2] = st.ltbl;
				rd_val[LADDR_CH_LSB +: 2] = st.lch;
			end
			OFS_LDATA: rd_val[7:0] = (st.lch < 2'(NUM_CH)) ? rd_w[st.lch] : 8'h00;
			OFS_STATUS: begin
				rd_val[0] = st.busy;
				rd_val[STAT_PHASE_LSB +: 3] = st.phase;
				rd_val[STAT_MODE_LSB +: 2] = st.gmode;
			end
			default: hit = 1'b0;
		endcase
	end

	// ****************************************
	// dot engine and field decode
	// ****************************************
	logic start;
	logic [31:0] pix_cur;
	logic sel_cur;
	logic [1:0] ovl_cur;
	logic [7:0] pm;
	logic [2:0] wmux;

	assign start = clk_s && !st.clk_prev;
	assign sel_cur = st.grp.sel[st.phase];
	assign ovl_cur = st.grp.ovl[2*st.phase +: 2];
	assign pm = pix_cur[7:0] & st.pmask;
	assign wmux = pwdata[CTRL_MUX_LSB +: 3];

	// pixel of the current phase, lowest port first
	always_comb begin
		case (st.gmode)
			PMFC_MODE_16: pix_cur = 32'(st.grp.pix[16*st.phase +: 16]);
			PMFC_MODE_32: pix_cur = st.grp.pix[32*st.phase +: 32];
			default: pix_cur = 32'(st.grp.pix[8*st.phase +: 8]);
		endcase
	end

	// next state for bus, registers, serialiser and decode stage
	always_comb begin
		next_st = st;
		// one wait state, answer at the second access cycle
		next_st.ack = acc && !st.ack;
		if (acc && !st.ack) begin
			next_st.prdata = pwrite ? 32'h0000_0000 : rd_val;
			next_st.err = !hit;
		end
		if (wr_fire) begin
			case (paddr)
				OFS_CTRL: begin
					next_st.mode = pmfc_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
					next_st.mux = (wmux < MUX_MIN || wmux > MUX_MAX) ? MUX_RST : wmux;
					next_st.comp_val = pwdata[CTRL_COMP_BIT];
				end
				OFS_PMASK: next_st.pmask = pwdata[7:0];
				OFS_OMASK: next_st.omask = pwdata[1:0];
				OFS_LADDR: begin
					next_st.lidx = pwdata[7:0];
					next_st.ltbl = pwdata[LADDR_TBL_LSB +: 2];
					next_st.lch = pwdata[LADDR_CH_LSB +: 2];
				end
				default: ;
			endcase
		end
		// group as it stood just before the input clock edge
		next_st.clk_prev = clk_s;
		next_st.prev_grp = grp_s;
		if (start) begin
			next_st.grp = st.prev_grp;
			next_st.busy = 1'b1;
			next_st.phase = 3'h0;
			next_st.gmux = st.mux;
			next_st.gmode = st.mode;
		end else if (st.busy) begin
			// factor dots per input period at pclk rate
			next_st.phase = st.phase + 3'h1;
			if (st.phase == st.gmux - 3'h1) begin
				next_st.busy = 1'b0;
				next_st.phase = 3'h0;
			end
		end
		// decode stage, one dot per cycle while busy
		next_st.s_val = st.busy;
		next_st.s_pse = pm;
		next_st.s_oidx = ovl_cur & st.omask;
		next_st.s_ohit = (ovl_cur & st.omask) != 2'h0;
		next_st.s_zero = !st.grp.blank_n;
		case (st.gmode)
			PMFC_MODE_16: begin
				next_st.s_rgb[0] = {pix_cur[15:10], 2'h0};
				next_st.s_rgb[1] = {pix_cur[9:4], 2'h0};
				next_st.s_rgb[2] = {pix_cur[3:0], 4'h0};
				next_st.s_use_p = 1'b0;
			end
			PMFC_MODE_32: begin
				next_st.s_rgb[0] = pix_cur[31:24];
				next_st.s_rgb[1] = pix_cur[23:16];
				next_st.s_rgb[2] = pix_cur[15:8];
				// per-dot field choice, no limit on switches
				next_st.s_use_p = st.comp_val ? (pm != 8'h00) : sel_cur;
			end
			default: begin
				next_st.s_rgb = '0;
				next_st.s_use_p = 1'b1;
			end
		endcase
		next_st.out_val = st.s_val;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{mode: MODE_RST, gmode: MODE_RST, mux: MUX_RST, gmux: MUX_RST, pmask: PMASK_RST,
				omask: OMASK_RST, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign prdata = st.prdata;
	assign pready = st.ack;
	assign pslverr = st.ack && st.err;
	assign dot_valid = st.out_val;
	assign red = colour_w[0];
	assign green = colour_w[1];
	assign blue = colour_w[2];

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_step;
		st.busy && !start && st.phase != st.gmux - 3'h1;
	endsequence

	sequence s_last;
		st.busy && !start && st.phase == st.gmux - 3'h1;
	endsequence

	a_phase_ascend: assert property (s_step |=> st.busy && st.phase == $past(st.phase) + 3'h1)
		else $error("phase did not advance by one");

	a_burst_end: assert property (s_last |=> !st.busy ##1 !st.s_val)
		else $error("dot burst ran past the factor");

	a_group_load: assert property (start |=> st.busy && st.phase == 3'h0 && st.grp == $past(st.prev_grp))
		else $error("group not captured on input edge");

	a_rgb16_split: assert property (st.busy && st.gmode == PMFC_MODE_16 |=>
		st.s_rgb[0] == {$past(pix_cur[15:10]), 2'h0} && st.s_rgb[2] == {$past(pix_cur[3:0]), 4'h0})
		else $error("16 bit component layout wrong");

	a_pseudo_mask: assert property (st.busy |=> st.s_pse == ($past(pix_cur[7:0]) & $past(st.pmask)))
		else $error("pseudo index not masked");

	a_mode8_pseudo: assert property (st.busy && st.gmode == PMFC_MODE_8 |=> st.s_use_p)
		else $error("8 bit pixel not taken as pseudo");

	a_pin_select: assert property (st.busy && st.gmode == PMFC_MODE_32 && !st.comp_val |=>
		st.s_use_p == $past(sel_cur))
		else $error("field select pin ignored");

	a_value_select: assert property (st.busy && st.gmode == PMFC_MODE_32 && st.comp_val |=>
		st.s_use_p == ($past(pm) != 8'h00))
		else $error("zero test choice wrong");

	a_overlay_gate: assert property (st.busy |=> st.s_ohit == (($past(ovl_cur) & $past(st.omask)) != 2'h0))
		else $error("overlay gating wrong");

	a_blank_zero: assert property (st.s_val && st.s_zero |=> dot_valid && red == 8'h00 && blue == 8'h00)
		else $error("blank did not force zero");

	a_apb_wait: assert property (acc && !st.ack |=> pready ##1 !pready)
		else $error("apb answer not after one wait state");

endmodule

/* verification/pmfc_src_model.sv */
// pmfc_src_model: behavioural video source handing one parallel pixel group per input clock
`timescale 1ns/1ps
module pmfc_src_model #(
	parameter int MAX_MUX = 5,
	parameter int SETUP = 3,
	parameter int HOLD = 4,
	parameter int IDLE = 6
) (
	// clock
	input wire logic pclk,
	// low rate pixel pins
	output logic low_rate_input_clock,
	output logic [32*MAX_MUX-1:0] pix_in,
	output logic [MAX_MUX-1:0] field_choose_pins,
	output logic [2*MAX_MUX-1:0] overlay_in,
	output logic blank_n
);
	// input clock stands low between groups
	initial begin
		low_rate_input_clock = 1'b0;
		pix_in = '0;
		field_choose_pins = '0;
		overlay_in = '0;
		blank_n = 1'b1;
	end

	// one group per input period, stable around the rising edge
	task automatic send(input logic [32*MAX_MUX-1:0] px, input logic [MAX_MUX-1:0] pins,
		input logic [2*MAX_MUX-1:0] ov, input logic bl);
		@(posedge pclk);
		pix_in <= px;
		field_choose_pins <= pins;
		overlay_in <= ov;
		blank_n <= bl;
		repeat (SETUP) @(posedge pclk);
		low_rate_input_clock <= 1'b1;
		repeat (HOLD) @(posedge pclk);
		low_rate_input_clock <= 1'b0;
		// hold time over: lines stop showing the old group
		pix_in <= ~px;
		field_choose_pins <= ~pins;
		overlay_in <= ~ov;
		blank_n <= ~bl;
		repeat (IDLE) @(posedge pclk);
	endtask
endmodule

/* verification/tb_pixel_mux_field_compositor.sv */
// tb_pixel_mux_field_compositor: self-checking bench for the pixel compositor
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin bad_count++; \
	$display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module tb_pixel_mux_field_compositor import pmfc_pkg::*;;
	localparam logic [159:0] PXA = 160'h9B27E4D1_00FF8C33_6A15C0F2_4E81379D_D25B06A8;
	localparam logic [159:0] PXB = 160'h11223308_44556633_77889900_AABBCCA5_DDEEFF0F;
	// clock, reset and apb
	logic pclk;
	logic presetn;
	logic [7:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	// pixel pins and colour stream
	logic low_rate_input_clock;
	logic [159:0] pix_in;
	logic [4:0] field_choose_pins;
	logic [9:0] overlay_in;
	logic blank_n;
	logic dot_valid;
	logic [7:0] red;
	logic [7:0] green;
	logic [7:0] blue;
	// bench state
	int bad_count = 0;
	int tests_run = 0;
	int fac;
	logic [1:0] md;
	logic cm;
	logic [7:0] pm;
	logic [1:0] om;
	logic [31:0] rd;
	logic er;
	int f;
	int c;
	int t;
	int i;

	pmfc_top #(.MAX_MUX(5)) i_pmfc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .low_rate_input_clock(low_rate_input_clock), .pix_in(pix_in),
		.field_choose_pins(field_choose_pins), .overlay_in(overlay_in), .blank_n(blank_n),
		.dot_valid(dot_valid), .red(red), .green(green), .blue(blue));

	pmfc_src_model #(.MAX_MUX(5)) i_pmfc_src_model (.pclk(pclk), .low_rate_input_clock(low_rate_input_clock),
		.pix_in(pix_in), .field_choose_pins(field_choose_pins), .overlay_in(overlay_in), .blank_n(blank_n));

	// ****************************************
	// clock, verdict and reference model
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// table contents loaded by the bench
	function automatic logic [7:0] tbl_val(input logic [1:0] ch, input logic [1:0] tb, input logic [7:0] ix);
		return ix ^ {ch, tb, 4'h5};
	endfunction

	// expected colour of one dot
	function automatic logic [7:0] col(input logic [1:0] ch, input logic [31:0] w, input logic pin,
		input logic [1:0] ov, input logic bl);
		logic [7:0] ps;
		logic [7:0] cv;
		ps = w[7:0] & pm;
		cv = (ch == 2'h0) ? w[31:24] : (ch == 2'h1) ? w[23:16] : w[15:8];
		if (md == 2'h1) begin
			cv = (ch == 2'h0) ? {w[15:10], 2'h0} : (ch == 2'h1) ? {w[9:4], 2'h0} : {w[3:0], 4'h0};
		end
		if (!bl) return 8'h00;
		if ((ov & om) != 2'h0) return tbl_val(ch, 2'h2, {6'h0, ov & om});
		if (md == 2'h0 || md == 2'h3 || (md == 2'h2 && (cm ? ps != 8'h00 : pin))) return tbl_val(ch, 2'h1, ps);
		return tbl_val(ch, 2'h0, cv);
	endfunction

	// ****************************************
	// bus and stream tasks
	// ****************************************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// pready and read data are taken at the rising edge that ends the access
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		if (n >= 20) begin
			bad_count++;
			$display("mismatch pready expected 1 seen timeout");
			test_done();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cfg(input logic [1:0] m, input logic [2:0] fv, input logic cc, input logic [7:0] p,
		input logic [1:0] o);
		apb(1'b1, OFS_CTRL, {26'h0, cc, fv, m});
		apb(1'b1, OFS_PMASK, {24'h0, p});
		apb(1'b1, OFS_OMASK, {30'h0, o});
		md = m;
		fac = fv;
		cm = cc;
		pm = p;
		om = o;
	endtask

	// send one group and compare every dot of its burst
	task automatic run(input logic [159:0] px, input logic [4:0] pins, input logic [9:0] ov, input logic bl);
		logic [31:0] w;
		int n;
		int k;
		fork
			i_pmfc_src_model.send(px, pins, ov, bl);
			begin
				n = 0;
				do begin
					@(negedge pclk);
					n++;
				end while (dot_valid !== 1'b1 && n < 40);
				if (n >= 40) begin
					bad_count++;
					$display("mismatch dot_valid expected 1 seen timeout");
					test_done();
				end
				for (k = 0; k < fac; k++) begin
					w = (md == 2'h2) ? px[32*k+:32] : (md == 2'h1) ? {16'h0, px[16*k+:16]} : {24'h0, px[8*k+:8]};
					`CHK("dot_valid", 1'b1, dot_valid)
					`CHK("red", col(2'h0, w, pins[k], ov[2*k+:2], bl), red)
					`CHK("green", col(2'h1, w, pins[k], ov[2*k+:2], bl), green)
					`CHK("blue", col(2'h2, w, pins[k], ov[2*k+:2], bl), blue)
					@(negedge pclk);
				end
				`CHK("dot_valid end", 1'b0, dot_valid)
			end
		join
	endtask

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK("ctrl reset", 32'h0000_0008, rd)
		apb(1'b0, OFS_PMASK, 32'h0);
		`CHK("pmask reset", 32'h0000_00FF, rd)
		apb(1'b0, OFS_OMASK, 32'h0);
		`CHK("omask reset", 32'h0000_0000, rd)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped err", 1'b1, er)
		`CHK("unmapped data", 32'h0000_0000, rd)
		apb(1'b1, 8'h20, 32'hFFFF_FFFF);
		`CHK("unmapped wr err", 1'b1, er)
		// factor 7 is out of range and must fall back to 2
		apb(1'b1, OFS_CTRL, 32'h0000_003D);
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK("ctrl clamp", 32'h0000_0029, rd)
		// fill every rgb and pseudo entry and overlay entries 1 to 3, then read one per table back
		for (c = 0; c < 3; c++) begin
			for (t = 0; t < 3; t++) begin
				for (i = (t == 2) ? 1 : 0; i < ((t == 2) ? 4 : 256); i++) begin
					apb(1'b1, OFS_LADDR, {20'h0, c[1:0], t[1:0], i[7:0]});
					apb(1'b1, OFS_LDATA, {24'h0, tbl_val(c[1:0], t[1:0], i[7:0])});
				end
				i = (t == 2) ? 2 : 8'hC3;
				apb(1'b1, OFS_LADDR, {20'h0, c[1:0], t[1:0], i[7:0]});
				apb(1'b0, OFS_LDATA, 32'h0);
				`CHK("table readback", {24'h0, tbl_val(c[1:0], t[1:0], i[7:0])}, rd)
			end
		end
		// every factor in 8 bit mode
		for (f = 2; f <= 5; f++) begin
			cfg(2'h0, f[2:0], 1'b0, 8'hFF, 2'h0);
			run(PXA, 5'h1F, 10'h0, 1'b1);
		end
		cfg(2'h0, 3'h5, 1'b0, 8'h0F, 2'h0);
		run(PXA, 5'h0, 10'h0, 1'b1);
		cfg(2'h1, 3'h5, 1'b0, 8'hFF, 2'h0);
		run(PXA, 5'h0A, 10'h0, 1'b1);
		cfg(2'h2, 3'h5, 1'b0, 8'hFF, 2'h0);
		run(PXB, 5'h0D, 10'h0, 1'b1);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("status idle", 32'h0000_0020, rd)
		cfg(2'h2, 3'h5, 1'b1, 8'hF0, 2'h0);
		run(PXB, 5'h12, 10'h0, 1'b1);
		// each overlay mask against every overlay code
		for (f = 0; f < 4; f++) begin
			cfg(2'h0, 3'h4, 1'b0, 8'hFF, f[1:0]);
			run(PXA, 5'h0, 10'h2E4, 1'b1);
		end
		run(PXA, 5'h0, 10'h2E4, 1'b0);
		cfg(2'h3, 3'h3, 1'b0, 8'hFF, 2'h0);
		run(PXA, 5'h1F, 10'h0, 1'b1);
		test_done();
	end
endmodule
